// [rcc_pkg.sv]
// Shared constants, field positions and carrier types of the clock control block
package rcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          LOSS_TIME_NS  = 100_000;
  // Least time without an edge before the clock is called stopped, rounded up
  localparam int          LOSS_CYCLES   = (LOSS_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int          HALF_PULSES   = 16384;
  localparam int          SYNC_WINDOW   = 32;
  localparam int          SECS_PER_MIN  = 60;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_TIME      = 8'h04;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] TIME_RESET    = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int          CAL_LSB       = 16;
  localparam int          CAL_MSB       = 25;
  localparam int          ON_BIT        = 15;
  localparam int          HALT_WHEN_IDLE_BIT      = 13;
  localparam int          SEL_BIT       = 7;
  localparam int          CLKON_BIT     = 6;
  localparam int          WREN_BIT      = 3;
  localparam int          SYNC_BIT      = 2;
  localparam int          HALF_BIT      = 1;
  localparam int          OE_BIT        = 0;

  // Time register fields
  localparam int          SEC_LSB       = 8;
  localparam int          SEC_MSB       = 14;
  localparam int          MIN_LSB       = 16;
  localparam int          MIN_MSB       = 22;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } rcc_bus_s;

  typedef struct packed {
    logic [9:0] cal;
    logic       on;
    logic       halt_when_idle;
    logic       sel;
    logic       wren;
    logic       oe;
  } rcc_ctrl_s;

endpackage : rcc_pkg

// [rcc_top.sv]
// Control, calibration and output logic of the real-time clock
`timescale 1ns/100ps
module rcc_top #(
  parameter int HALF_PULSES = rcc_pkg::HALF_PULSES
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire rcc_pkg::rcc_bus_s bus,
  output logic [31:0]            rdata,
  input  wire logic              tick_clk_pin,
  input  wire logic              unlock_seq_open,
  input  wire logic              cpu_idle,
  input  wire logic              alarm_pulse,
  output logic                   calendar_output_pin,
  output logic                   calendar_output_pin_oe,
  output logic                   bus_clock_enable
);
  import rcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Sign-extend the calibration code to the prescaler width
  function automatic logic signed [16:0] cal_ext(input logic [9:0] c);
    cal_ext = {{7{c[9]}}, c};
  endfunction : cal_ext

  localparam logic signed [16:0] HALF_LAST = 17'(HALF_PULSES - 1);
  localparam logic signed [16:0] SYNC_FROM = 17'(HALF_PULSES - SYNC_WINDOW);
  localparam logic [11:0]        LOSS_MAX  = 12'(LOSS_CYCLES);
  localparam logic [6:0]         SEC_LAST  = 7'(SECS_PER_MIN - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Tick pin synchroniser; the first stage feeds only the second
  logic       sync1_reg;
  logic       sync2_reg;
  logic       sync3_reg;
  logic       tick_rise;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= tick_clk_pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign tick_rise = sync2_reg & ~sync3_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  rcc_ctrl_s  ctrl_reg;
  rcc_ctrl_s  ctrl_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic       wr_ctrl;
  logic       wr_time;
  logic       rd_any;

  // Address decode
  always_comb begin
    wr_ctrl = 1'b0;
    wr_time = 1'b0;
    if (bus.wr && bus.addr == OFF_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (bus.wr && bus.addr == OFF_TIME) begin
      wr_time = 1'b1;
    end
  end

  assign rd_any = bus.rd;

  ////////////////////////////////////////////////////////////////////////////
  // Time keeping state
  logic signed [16:0] presc_reg;
  logic signed [16:0] presc_next;
  logic [6:0] sec_reg;
  logic [6:0] sec_next;
  logic [6:0] min_reg;
  logic [6:0] min_next;
  logic       half_reg;
  logic       half_next;
  logic [11:0] loss_reg;
  logic [11:0] loss_next;
  logic       run;
  logic       half_end;
  logic       minute_roll;
  logic       clk_running;
  logic       pending;

  // Frozen when disabled, or when idle with halt-in-idle set
  assign run              = ctrl_reg.on & ~(ctrl_reg.halt_when_idle & cpu_idle);
  assign bus_clock_enable = ~(ctrl_reg.halt_when_idle & cpu_idle);
  assign half_end         = run & tick_rise & (presc_reg >= HALF_LAST);
  assign minute_roll      = half_end & half_reg & (sec_reg == SEC_LAST);
  assign clk_running      = ctrl_reg.on & (loss_reg < LOSS_MAX);
  assign pending          = run & (presc_reg >= SYNC_FROM) & half_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Control register next value
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      // Only writable fields are taken; status and reserved bits drop away
      ctrl_next.cal  = bus.wdata[CAL_MSB:CAL_LSB];
      ctrl_next.halt_when_idle = bus.wdata[HALT_WHEN_IDLE_BIT];
      ctrl_next.sel  = bus.wdata[SEL_BIT];
      ctrl_next.oe   = bus.wdata[OE_BIT];
      // Enable moves only with the unlock flag already open
      if (ctrl_reg.wren) begin
        ctrl_next.on = bus.wdata[ON_BIT];
      end
      // Clearing the unlock flag is always allowed; setting needs the sequence
      if (!bus.wdata[WREN_BIT]) begin
        ctrl_next.wren = 1'b0;
      end else if (unlock_seq_open) begin
        ctrl_next.wren = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time keeping next values
  always_comb begin
    presc_next = presc_reg;
    sec_next   = sec_reg;
    min_next   = min_reg;
    half_next  = half_reg;
    loss_next  = loss_reg;
    // Watchdog on the tick pin; saturates so a dead clock stays reported
    if (tick_rise) begin
      loss_next = 12'h000;
    end else if (loss_reg < LOSS_MAX) begin
      loss_next = loss_reg + 12'h001;
    end
    if (wr_time) begin
      // Loading the time restarts the second, so the half flag goes low
      sec_next   = bus.wdata[SEC_MSB:SEC_LSB];
      min_next   = bus.wdata[MIN_MSB:MIN_LSB];
      presc_next = 17'sd0;
      half_next  = 1'b0;
    end else if (half_end) begin
      half_next  = ~half_reg;
      presc_next = 17'sd0;
      if (half_reg) begin
        if (sec_reg == SEC_LAST) begin
          sec_next = 7'h00;
          min_next = (min_reg == SEC_LAST) ? 7'h00 : min_reg + 7'h01;
          // Positive code shortens the next count, negative lengthens it
          presc_next = cal_ext(ctrl_reg.cal);
        end else begin
          sec_next = sec_reg + 7'h01;
        end
      end
    end else if (run && tick_rise) begin
      presc_next = presc_reg + 17'sd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; unmapped addresses read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd_any && bus.addr == OFF_CTRL) begin
      rdata_next[CAL_MSB:CAL_LSB] = ctrl_reg.cal;
      rdata_next[ON_BIT]          = ctrl_reg.on;
      rdata_next[HALT_WHEN_IDLE_BIT]        = ctrl_reg.halt_when_idle;
      rdata_next[SEL_BIT]         = ctrl_reg.sel;
      rdata_next[CLKON_BIT]       = clk_running;
      rdata_next[WREN_BIT]        = ctrl_reg.wren;
      rdata_next[SYNC_BIT]        = pending;
      rdata_next[HALF_BIT]        = half_reg;
      rdata_next[OE_BIT]          = ctrl_reg.oe;
    end else if (rd_any && bus.addr == OFF_TIME) begin
      rdata_next[SEC_MSB:SEC_LSB] = sec_reg;
      rdata_next[MIN_MSB:MIN_LSB] = min_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; rst is the power-on reset, other resets never reach them
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_reg  <= rcc_ctrl_s'(CTRL_RESET[14:0]);
      rdata_reg <= 32'h0000_0000;
      presc_reg <= 17'sd0;
      sec_reg   <= TIME_RESET[SEC_MSB:SEC_LSB];
      min_reg   <= TIME_RESET[MIN_MSB:MIN_LSB];
      half_reg  <= 1'b0;
      loss_reg  <= LOSS_MAX;
    end else begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
      presc_reg <= presc_next;
      sec_reg   <= sec_next;
      min_reg   <= min_next;
      half_reg  <= half_next;
      loss_reg  <= loss_next;
    end
  end

  assign rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Output pin; registered so the pin never glitches on a select change
  logic pin_reg;
  logic pin_next;
  logic pin_oe_reg;
  logic pin_oe_next;

  always_comb begin
    pin_next    = ctrl_reg.sel ? half_reg : alarm_pulse;
    pin_oe_next = ctrl_reg.oe & ctrl_reg.on;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_reg    <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else begin
      pin_reg    <= pin_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  // Data held low while not enabled so a disabled pin shows a clean level
  assign calendar_output_pin    = pin_reg & pin_oe_reg;
  assign calendar_output_pin_oe = pin_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence seq_sec_write;
    bus.wr && bus.addr == OFF_TIME;
  endsequence

  // A time write in the rollover cycle wins, so it is left out here
  sequence seq_minute_roll;
    minute_roll && !wr_time;
  endsequence

  AST_HALF_CLEAR: assert property (seq_sec_write |=> !half_reg)
    else $error("half flag not cleared by seconds write");

  AST_ON_LOCKED: assert property (wr_ctrl && !ctrl_reg.wren |=> ctrl_reg.on == $past(ctrl_reg.on))
    else $error("enable moved without unlock");

  AST_UNLOCK_GATED: assert property (wr_ctrl && !ctrl_reg.wren && !unlock_seq_open |=> !ctrl_reg.wren)
    else $error("unlock flag set outside sequence");

  AST_CAL_LOAD: assert property (seq_minute_roll |=> presc_reg == cal_ext($past(ctrl_reg.cal)))
    else $error("calibration not loaded at minute rollover");

  AST_FROZEN: assert property (!run && !wr_time |=> presc_reg == $past(presc_reg) && sec_reg == $past(sec_reg))
    else $error("time moved while not running");

  AST_PIN_SOURCE: assert property (ctrl_reg.sel && ctrl_reg.oe && ctrl_reg.on && !wr_ctrl
      |=> calendar_output_pin == $past(half_reg))
    else $error("pin does not carry seconds clock");

  AST_PIN_OFF: assert property (!ctrl_reg.oe |=> !calendar_output_pin_oe && !calendar_output_pin)
    else $error("pin driven with output disabled");

  AST_RSVD_ZERO: assert property (rd_any && bus.addr == OFF_CTRL
      |=> rdata[31:26] == 6'h00 && rdata[14] == 1'b0 && rdata[12:8] == 5'h00 && rdata[5:4] == 2'h0)
    else $error("reserved control bits not zero");

  // Checker-only count of cycles since the last synced edge, kept apart from the design's watchdog
  logic [11:0] quiet_reg;
  logic [11:0] quiet_next;

  // Saturates so a long dead spell stays visible
  always_comb begin
    quiet_next = quiet_reg;
    if (tick_rise) begin
      quiet_next = 12'h000;
    end else if (quiet_reg != 12'hFFF) begin
      quiet_next = quiet_reg + 12'h001;
    end
  end

  // Starts saturated: no edge has been seen after power-on
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      quiet_reg <= 12'hFFF;
    end else begin
      quiet_reg <= quiet_next;
    end
  end

  AST_CLK_LOST: assert property (quiet_reg >= LOSS_MAX |-> !clk_running)
    else $error("running flag stays up with a dead clock");

  AST_CLK_SEEN: assert property (tick_rise && ctrl_reg.on && !wr_ctrl |=> clk_running)
    else $error("running flag low right after a tick edge");

  AST_STATUS_RO: assert property (wr_ctrl && !wr_time && !half_end |=> half_reg == $past(half_reg))
    else $error("status bit taken from write data");

endmodule : rcc_top

// [rcc_top_tb.sv]
// Self-checking testbench of the clock control block, driven over its register port
`timescale 1ns/100ps
module rcc_top_tb;
  import rcc_pkg::*;
  // Short half-second so that a whole minute fits in about 31 thousand cycles
  localparam int HP = 64;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  rcc_bus_s    bus = '0;
  logic [31:0] rdata;
  logic        tick_clk_pin = 1'b0;
  logic        unlock_seq_open = 1'b0;
  logic        cpu_idle = 1'b0;
  logic        alarm_pulse = 1'b0;
  logic        pin;
  logic        pin_oe;
  logic        bus_clk_en;
  int          err_count = 0;
  int          comparisons = 0;
  logic [9:0]  cal_tab [5] = '{10'h000, 10'h005, 10'h3FD, 10'h03F, 10'h200};
  int          n_tab [5] = '{64, 59, 67, 1, 576};

  rcc_top #(.HALF_PULSES(HP)) uut (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata),
    .tick_clk_pin(tick_clk_pin), .unlock_seq_open(unlock_seq_open), .cpu_idle(cpu_idle),
    .alarm_pulse(alarm_pulse), .calendar_output_pin(pin), .calendar_output_pin_oe(pin_oe),
    .bus_clock_enable(bus_clk_en));

  // 25 MHz system clock
  always #20 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, reached from the main sequence or the watchdog
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : check_bit

  ////////////////////////////////////////////////////////////////////////////
  // Register port: one-cycle strobes, read data in the cycle after the strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask : wr_reg

  task automatic chk_reg(input string what, input logic [7:0] a, input logic [31:0] mask,
                         input logic [31:0] exp);
    @(posedge clock);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    check_word(what, exp, rdata & mask);
  endtask : chk_reg

  // Tick edges two cycles high, two low, then time for the synchroniser
  task automatic tick_edges(input int n);
    repeat (n) begin
      @(posedge clock);
      tick_clk_pin <= 1'b1;
      repeat (2) @(posedge clock);
      tick_clk_pin <= 1'b0;
      @(posedge clock);
    end
    repeat (4) @(posedge clock);
  endtask : tick_edges

  task automatic chk_pins(input logic exp_d, input logic exp_oe);
    repeat (3) @(posedge clock);
    #1;
    check_bit("pin data", exp_d, pin);
    check_bit("pin enable", exp_oe, pin_oe);
  endtask : chk_pins

  // Cuts a hang short
  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    $display("unexpected run length: expected end, seen timeout");
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    chk_reg("control", OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    chk_reg("time", OFF_TIME, 32'hFFFF_FFFF, 32'h0000_0000);
    wr_reg(OFF_CTRL, 32'hFFFF_FFFF);
    chk_reg("control", OFF_CTRL, 32'hFFFF_FFFF, 32'h03FF_2081);
    unlock_seq_open <= 1'b1;
    wr_reg(OFF_CTRL, 32'h0000_0008);
    unlock_seq_open <= 1'b0;
    chk_reg("control", OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0008);
    wr_reg(OFF_CTRL, 32'hFFFF_FFFF);
    chk_reg("control", OFF_CTRL, 32'hFFFF_FFFF, 32'h03FF_A089);
    wr_reg(8'h08, 32'hFFFF_FFFF);
    chk_reg("unmapped", 8'h08, 32'hFFFF_FFFF, 32'h0000_0000);
    chk_pins(1'b0, 1'b1);
    alarm_pulse <= 1'b1;
    wr_reg(OFF_CTRL, 32'h0000_8009);
    chk_pins(1'b1, 1'b1);
    wr_reg(OFF_CTRL, 32'h0000_8008);
    chk_pins(1'b0, 1'b0);
    alarm_pulse <= 1'b0;
    // Idle gating only with halt_when_idle set
    cpu_idle <= 1'b1;
    chk_pins(1'b0, 1'b0);
    check_bit("bus clock enable", 1'b1, bus_clk_en);
    wr_reg(OFF_CTRL, 32'h0000_A008);
    @(posedge clock);
    #1;
    check_bit("bus clock enable", 1'b0, bus_clk_en);
    cpu_idle <= 1'b0;
    wr_reg(OFF_CTRL, 32'h0000_8008);
    tick_edges(8);
    chk_reg("running flag", OFF_CTRL, 32'h0000_0040, 32'h0000_0040);
    // Half flag set, then cleared by a seconds write
    wr_reg(OFF_TIME, 32'h0000_3B00);
    tick_edges(HP);
    chk_reg("half flag", OFF_CTRL, 32'h0000_0002, 32'h0000_0002);
    chk_reg("pending flag", OFF_CTRL, 32'h0000_0004, 32'h0000_0000);
    // Second half running, prescaler moved into the rollover window
    tick_edges(HP - SYNC_WINDOW);
    chk_reg("pending flag", OFF_CTRL, 32'h0000_0004, 32'h0000_0004);
    wr_reg(OFF_CTRL, 32'h0000_8008);
    chk_reg("half flag", OFF_CTRL, 32'h0000_0002, 32'h0000_0002);
    wr_reg(OFF_TIME, 32'h0000_3B00);
    chk_reg("half flag", OFF_CTRL, 32'h0000_0002, 32'h0000_0000);
    // Calibration applied once after each minute rollover
    for (int i = 0; i < 5; i++) begin
      wr_reg(OFF_CTRL, {6'h00, cal_tab[i], 16'h8008});
      wr_reg(OFF_TIME, 32'h0000_3B00);
      tick_edges(2 * HP);
      chk_reg("time", OFF_TIME, 32'hFFFF_FFFF, 32'h0001_0000);
      tick_edges(n_tab[i] - 1);
      chk_reg("half flag", OFF_CTRL, 32'h0000_0002, 32'h0000_0000);
      tick_edges(1);
      chk_reg("half flag", OFF_CTRL, 32'h0000_0002, 32'h0000_0002);
    end
    // Disabled module keeps no time; wr_reg leaves an idle cycle after the enable is cleared
    wr_reg(OFF_CTRL, 32'h0000_0008);
    wr_reg(OFF_TIME, 32'h0000_0000);
    tick_edges(130);
    chk_reg("time", OFF_TIME, 32'hFFFF_FFFF, 32'h0000_0000);
    chk_reg("running flag", OFF_CTRL, 32'h0000_0040, 32'h0000_0000);
    // Stopped tick clock drops the running flag
    wr_reg(OFF_CTRL, 32'h0000_8008);
    tick_edges(4);
    repeat (2600) @(posedge clock);
    chk_reg("running flag", OFF_CTRL, 32'h0000_0040, 32'h0000_0000);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    chk_reg("control", OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    tally_and_finish();
  end
endmodule : rcc_top_tb
